// ===== inc/rx_gain_pkg.sv
`default_nettype none
package rx_gain_pkg;
   // clock and timing
   localparam int CLK_PERIOD_PS     = 10000;
   localparam int SQ_DELAY_PS       = 18880000;
   localparam int SQ_DELAY_CYC      = (SQ_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SQ_PERIOD_US      = 50;
   localparam int SQ_PERIOD_CYC     = SQ_PERIOD_US * 1000000 / CLK_PERIOD_PS;
   // register byte offsets
   localparam logic [7:0] OFS_FILTER  = 8'h00;
   localparam logic [7:0] OFS_FIRST   = 8'h04;
   localparam logic [7:0] OFS_LOOP    = 8'h08;
   localparam logic [7:0] OFS_MANUAL  = 8'h0C;
   localparam logic [7:0] OFS_SQTIMER = 8'h10;
   localparam logic [7:0] OFS_STATE   = 8'h14;
   localparam logic [7:0] OFS_STRENGTH= 8'h18;
   localparam logic [7:0] OFS_CMD     = 8'h1C;
   // loop configuration field positions
   localparam int LOOP_SQ_EN    = 0;
   localparam int LOOP_SQ_RATIO = 1;
   localparam int LOOP_AGC_EN   = 2;
   localparam int LOOP_AGC_MODE = 3;
   localparam int LOOP_AGC_ALG  = 4;
   localparam int LOOP_AGC_RAT  = 5;
   localparam int LOOP_RX_EN    = 6;
   // command bits
   localparam int CMD_RESET_GAIN = 0;
   localparam int CMD_CLEAR_STR  = 1;
   // filter and first-stage field positions
   localparam int FLT_LP_LSB = 4;
   localparam int FIRST_BOOST = 3;
   // reset values
   localparam logic [7:0] FILTER_RST = 8'h00;
   localparam logic [3:0] FIRST_RST  = 4'h6;
   localparam logic [6:0] LOOP_RST   = 7'h00;
   localparam logic [3:0] MANUAL_RST = 4'h0;
   localparam logic [7:0] SQTIMER_RST= 8'h00;
   // gain ladder
   localparam logic [3:0] STATE_MAX    = 4'hA;
   localparam logic [3:0] WINDOW_STEPS = 4'h4;
   localparam logic [3:0] STRENGTH_MAX = 4'hD;
   localparam logic [3:0] SQ_TRANS_LIM = 4'h2;
   localparam logic [3:0] AGC_PULSES   = 4'h8;
   // low-pass cut-off
   typedef enum logic [2:0] {LP_1200K, LP_600K, LP_300K, LP_2M, LP_7M, LP_NONE} lowpass_t;
   // first/third zero
   typedef enum logic [2:0] {FZ_60K, FZ_40K, FZ_12K, FZ_600K, FZ_NONE} first_zero_t;
   typedef enum logic [1:0] {TZ_400K, TZ_200K, TZ_80K, TZ_NONE} third_zero_t;
endpackage
`default_nettype wire

// ===== rtl/rx_gain_agc_squelch_rssi.sv
// Contract
// (RL1) first stage: six 2.5 dB reduction steps plus 5.5 dB boost option
// (RL2) first-stage gain only changes by register write; reset selects minimum gain
// (RL3) low-pass code 000/001/010/100/110 gives 1200k/600k/300k/2M/7M, others unused
// (RL4) four shared zero bits fix first and third stage zero together
// (RL5) stage two/three gain drops from 23 dB in six 3 dB steps, loop or manual
// (RL6) reset-gain command clears squelch gain and loads manual setting
// (RL7) digitizer window has five 3 dB settings, loop-adjusted or manual
// (RL8) eleven gain states: four window steps then six gain steps
// (RL9) loops start from manual setting; readable state shows actual gain
// (RL10) squelch starts 18.88 us after transmit end, stops at mask timer match
// (RL11) squelch ratio bit picks main digitizer or six-times window comparator
// (RL12) more than two transitions in 50 us drops gain one step, repeated
// (RL13) auto gain runs while receiver-on high; falling edge captures state
// (RL14) auto gain steps down while ratio-3 or ratio-6 comparator toggles
// (RL15) mode bit: whole reception or only first eight subcarrier pulses
// (RL16) algorithm bit: preset start at maximum window, or reset start
// (RL17) strength restarts at rise, peak-holds while high, freezes low, resets on reduction
// (RL18) strength is 4 bits, 2.8 dB per step, maximum code Dh
// (RL19) clear-strength command zeroes held strength and restarts measurement
// (RL20) receiver powered only while the receiver enable bit is one
// (RL21) gain state saturates at maximum reduction and never below initial state
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module rx_gain_agc_squelch_rssi #(
   parameter int SQ_PERIOD = rx_gain_pkg::SQ_PERIOD_CYC
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // wishbone slave
   input  wire logic       cyc_i,
   input  wire logic       stb_i,
   input  wire logic       we_i,
   input  wire logic [7:0] adr_i,
   input  wire logic [3:0] sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]     dat_o,
   output logic            ack_o,
   // receive chain events
   input  wire logic       rx_on_i,
   input  wire logic       tx_end_i,
   input  wire logic [7:0] receive_mask_timer_i,
   input  wire logic       dig_main_i,
   input  wire logic       dig_win6_i,
   input  wire logic       dig_agc3_i,
   input  wire logic       dig_agc6_i,
   input  wire logic       subcarrier_pulse_i,
   input  wire logic [3:0] strength_a_i,
   input  wire logic [3:0] strength_b_i,
   // analog settings
   output logic            rx_power_o,
   output logic [2:0]      lowpass_o,
   output logic [2:0]      first_zero_o,
   output logic [1:0]      third_zero_o,
   output logic [2:0]      first_red_o,
   output logic            first_boost_o,
   output logic [2:0]      window_step_o,
   output logic [2:0]      stage23_red_o,
   output logic            squelch_active_o
);
   localparam int PW = $clog2(SQ_PERIOD + 1);
   localparam int DW = $clog2(rx_gain_pkg::SQ_DELAY_CYC + 1);
   localparam logic [DW-1:0] DELAY_LAST = DW'(rx_gain_pkg::SQ_DELAY_CYC - 1);
   localparam logic [PW-1:0] PERIOD_LAST = PW'(SQ_PERIOD - 1);

   logic [7:0]  filter_reg;
   logic [3:0]  first_reg;
   logic [6:0]  loop_reg;
   logic [3:0]  manual_reg;
   logic [7:0]  sqtimer_reg;
   logic [3:0]  state_reg;
   logic [3:0]  base_reg;
   logic [3:0]  captured_reg;
   logic [3:0]  str_reg [2];
   logic        ack_reg;
   logic [31:0] dat_reg;
   logic        rx_on_q_reg;
   logic        sq_wait_reg;
   logic        sq_on_reg;
   logic [DW-1:0] sq_dly_reg;
   logic [PW-1:0] sq_per_reg;
   logic [3:0]  sq_trans_reg;
   logic        sq_cmp_q_reg;
   logic        agc_cmp_q_reg;
   logic        pulse_q_reg;
   logic [3:0]  pulses_reg;

   // bus decode
   wire         req        = cyc_i & stb_i;
   wire         wr_fire    = req & we_i & ack_reg;
   wire         sel_lo     = sel_i[0];
   wire         wr_filter  = wr_fire & sel_lo & (adr_i == rx_gain_pkg::OFS_FILTER);
   wire         wr_first   = wr_fire & sel_lo & (adr_i == rx_gain_pkg::OFS_FIRST);
   wire         wr_loop    = wr_fire & sel_lo & (adr_i == rx_gain_pkg::OFS_LOOP);
   wire         wr_manual  = wr_fire & sel_lo & (adr_i == rx_gain_pkg::OFS_MANUAL);
   wire         wr_sqtimer = wr_fire & sel_lo & (adr_i == rx_gain_pkg::OFS_SQTIMER);
   wire         wr_cmd     = wr_fire & sel_lo & (adr_i == rx_gain_pkg::OFS_CMD);
   wire         cmd_reset  = wr_cmd & dat_i[rx_gain_pkg::CMD_RESET_GAIN];
   wire         cmd_clear  = wr_cmd & dat_i[rx_gain_pkg::CMD_CLEAR_STR];

   logic [31:0] rd_mux;
   always_comb begin
      unique case (adr_i)
         rx_gain_pkg::OFS_FILTER:   rd_mux = {24'h000000, filter_reg};
         rx_gain_pkg::OFS_FIRST:    rd_mux = {28'h0000000, first_reg};
         rx_gain_pkg::OFS_LOOP:     rd_mux = {25'h0000000, loop_reg};
         rx_gain_pkg::OFS_MANUAL:   rd_mux = {28'h0000000, manual_reg};
         rx_gain_pkg::OFS_SQTIMER:  rd_mux = {24'h000000, sqtimer_reg};
         rx_gain_pkg::OFS_STATE:    rd_mux = {28'h0000000, captured_reg};
         rx_gain_pkg::OFS_STRENGTH: rd_mux = {24'h000000, str_reg[1], str_reg[0]};
         default:                   rd_mux = 32'h00000000;
      endcase
   end

   // one wait state; unmapped addresses ack with zero data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end else begin
         ack_reg <= req & ~ack_reg;
         dat_reg <= rd_mux;
      end
   end
   assign ack_o = ack_reg;
   assign dat_o = dat_reg;

   // configuration registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         filter_reg  <= rx_gain_pkg::FILTER_RST;
         first_reg   <= rx_gain_pkg::FIRST_RST;        // see RL2
         loop_reg    <= rx_gain_pkg::LOOP_RST;
         manual_reg  <= rx_gain_pkg::MANUAL_RST;
         sqtimer_reg <= rx_gain_pkg::SQTIMER_RST;
      end else begin
         if (wr_filter)  filter_reg  <= dat_i[7:0];
         if (wr_first)   first_reg   <= dat_i[3:0];    // see RL2
         if (wr_loop)    loop_reg    <= dat_i[6:0];
         if (wr_manual)  manual_reg  <= (dat_i[3:0] > rx_gain_pkg::STATE_MAX) ?
                                        rx_gain_pkg::STATE_MAX : dat_i[3:0];
         if (wr_sqtimer) sqtimer_reg <= dat_i[7:0];
      end
   end

   wire sq_en    = loop_reg[rx_gain_pkg::LOOP_SQ_EN];
   wire sq_ratio = loop_reg[rx_gain_pkg::LOOP_SQ_RATIO];
   wire agc_en   = loop_reg[rx_gain_pkg::LOOP_AGC_EN];
   wire agc_mode = loop_reg[rx_gain_pkg::LOOP_AGC_MODE];
   wire agc_alg  = loop_reg[rx_gain_pkg::LOOP_AGC_ALG];
   wire agc_rat  = loop_reg[rx_gain_pkg::LOOP_AGC_RAT];
   wire rx_en    = loop_reg[rx_gain_pkg::LOOP_RX_EN];

   assign rx_power_o = rx_en;                          // see RL20
   // a receiver-on window without power is meaningless
   wire rx_on   = rx_on_i & rx_en;                     // see RL20
   wire rx_rise = rx_on & ~rx_on_q_reg;
   wire rx_fall = ~rx_on & rx_on_q_reg;

   // filter decode: zero bits [3:0], low-pass select in [6:4]
   wire [2:0] lp_code   = filter_reg[rx_gain_pkg::FLT_LP_LSB +: 3];
   wire [3:0] zero_code = filter_reg[3:0];
   always_comb begin
      unique case (lp_code)                            // see RL3
         3'h0:    lowpass_o = rx_gain_pkg::LP_1200K;
         3'h1:    lowpass_o = rx_gain_pkg::LP_600K;
         3'h2:    lowpass_o = rx_gain_pkg::LP_300K;
         3'h4:    lowpass_o = rx_gain_pkg::LP_2M;
         3'h6:    lowpass_o = rx_gain_pkg::LP_7M;
         default: lowpass_o = rx_gain_pkg::LP_NONE;
      endcase
      unique case (zero_code)                          // see RL4
         4'h0:    {first_zero_o, third_zero_o} = {rx_gain_pkg::FZ_60K, rx_gain_pkg::TZ_400K};
         4'h4:    {first_zero_o, third_zero_o} = {rx_gain_pkg::FZ_60K, rx_gain_pkg::TZ_200K};
         4'h2:    {first_zero_o, third_zero_o} = {rx_gain_pkg::FZ_40K, rx_gain_pkg::TZ_80K};
         4'h1:    {first_zero_o, third_zero_o} = {rx_gain_pkg::FZ_40K, rx_gain_pkg::TZ_200K};
         4'h3:    {first_zero_o, third_zero_o} = {rx_gain_pkg::FZ_12K, rx_gain_pkg::TZ_80K};
         4'h5:    {first_zero_o, third_zero_o} = {rx_gain_pkg::FZ_12K, rx_gain_pkg::TZ_200K};
         4'h8:    {first_zero_o, third_zero_o} = {rx_gain_pkg::FZ_600K, rx_gain_pkg::TZ_400K};
         4'hC:    {first_zero_o, third_zero_o} = {rx_gain_pkg::FZ_600K, rx_gain_pkg::TZ_200K};
         default: {first_zero_o, third_zero_o} = {rx_gain_pkg::FZ_NONE, rx_gain_pkg::TZ_NONE};
      endcase
   end

   // first stage: reduction 0..6 steps of 2.5 dB, boost adds 5.5 dB
   assign first_red_o   = (first_reg[2:0] > 3'h6) ? 3'h6 : first_reg[2:0];      // see RL1
   assign first_boost_o = first_reg[rx_gain_pkg::FIRST_BOOST];                   // see RL1

   // ladder mapping: window widens first, then stage two/three gain drops
   assign window_step_o = (state_reg > rx_gain_pkg::WINDOW_STEPS) ?
                          3'h4 : state_reg[2:0];                                 // see RL7 RL8
   assign stage23_red_o = (state_reg > rx_gain_pkg::WINDOW_STEPS) ?
                          3'(state_reg - rx_gain_pkg::WINDOW_STEPS) : 3'h0;      // see RL5
   assign squelch_active_o = sq_on_reg;

   // squelch window
   wire sq_cmp     = sq_ratio ? dig_win6_i : dig_main_i;                          // see RL11
   wire sq_edge    = sq_on_reg & (sq_cmp ^ sq_cmp_q_reg);
   wire sq_end     = sq_on_reg & (receive_mask_timer_i >= sqtimer_reg);           // see RL10
   wire sq_per_end = sq_on_reg & (sq_per_reg == PERIOD_LAST);
   wire at_max     = (state_reg == rx_gain_pkg::STATE_MAX);
   wire sq_step    = sq_per_end & (sq_trans_reg > rx_gain_pkg::SQ_TRANS_LIM) & ~at_max; // see RL12

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sq_wait_reg  <= 1'b0;
         sq_on_reg    <= 1'b0;
         sq_dly_reg   <= '0;
         sq_per_reg   <= '0;
         sq_trans_reg <= 4'h0;
         sq_cmp_q_reg <= 1'b0;
      end else begin
         sq_cmp_q_reg <= sq_cmp;
         if (tx_end_i & sq_en) begin                                              // see RL10
            sq_wait_reg <= 1'b1;
            sq_on_reg   <= 1'b0;
            sq_dly_reg  <= '0;
         end else if (sq_wait_reg) begin
            sq_dly_reg <= sq_dly_reg + 1'b1;
            if (sq_dly_reg == DELAY_LAST) begin
               sq_wait_reg <= 1'b0;
               sq_on_reg   <= 1'b1;
            end
         end else if (sq_end | ~sq_en) begin
            sq_on_reg <= 1'b0;
         end
         if (~sq_on_reg | sq_per_end) begin
            sq_per_reg   <= '0;
            sq_trans_reg <= 4'h0;
         end else begin
            sq_per_reg <= sq_per_reg + 1'b1;
            if (sq_edge & (sq_trans_reg != 4'hF)) sq_trans_reg <= sq_trans_reg + 1'b1;
         end
      end
   end

   // auto gain: any toggle on the ratio-3 or ratio-6 comparator picked by agc_rat drops one step
   wire agc_cmp    = agc_rat ? dig_agc6_i : dig_agc3_i;                           // see RL14
   wire pulse_rise = subcarrier_pulse_i & ~pulse_q_reg;
   wire agc_window = agc_mode | (pulses_reg < rx_gain_pkg::AGC_PULSES);           // see RL15
   wire agc_run    = agc_en & rx_on & rx_on_q_reg & agc_window;                   // see RL13
   wire agc_step   = agc_run & (agc_cmp ^ agc_cmp_q_reg) & ~at_max;               // see RL14
   wire [3:0] preset_state = (base_reg < rx_gain_pkg::WINDOW_STEPS) ?
                             rx_gain_pkg::WINDOW_STEPS : base_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_on_q_reg   <= 1'b0;
         agc_cmp_q_reg <= 1'b0;
         pulse_q_reg   <= 1'b0;
         pulses_reg    <= 4'h0;
      end else begin
         rx_on_q_reg   <= rx_on;
         agc_cmp_q_reg <= agc_cmp;
         pulse_q_reg   <= subcarrier_pulse_i;
         if (~rx_on)
            pulses_reg <= 4'h0;
         else if (pulse_rise & (pulses_reg < rx_gain_pkg::AGC_PULSES))
            pulses_reg <= pulses_reg + 1'b1;
      end
   end

   // gain state: base holds manual start plus squelch result
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg    <= rx_gain_pkg::MANUAL_RST;
         base_reg     <= rx_gain_pkg::MANUAL_RST;
         captured_reg <= rx_gain_pkg::MANUAL_RST;
      end else begin
         if (cmd_reset) begin                                                     // see RL6
            state_reg <= manual_reg;                                              // see RL9
            base_reg  <= manual_reg;
         end else if (sq_step) begin
            state_reg <= state_reg + 1'b1;                                        // see RL12
            base_reg  <= state_reg + 1'b1;
         end else if (rx_rise & agc_en & agc_alg) begin
            state_reg <= preset_state;                                            // see RL16
         end else if (rx_fall) begin
            state_reg <= base_reg;                                                // see RL13
         end else if (agc_step) begin
            state_reg <= state_reg + 1'b1;                                        // see RL21
         end
         if (rx_fall) captured_reg <= state_reg;                                  // see RL13
      end
   end

   // peak-hold strength per channel
   wire [3:0] str_in [2];
   assign str_in[0] = strength_a_i;
   assign str_in[1] = strength_b_i;
   for (genvar ch = 0; ch < 2; ch++) begin : g_str
      wire [3:0] clip = (str_in[ch] > rx_gain_pkg::STRENGTH_MAX) ?
                        rx_gain_pkg::STRENGTH_MAX : str_in[ch];                   // see RL18
      always_ff @(posedge clk_i) begin
         if (rst_i | cmd_reset | cmd_clear | rx_rise | agc_step)                  // see RL19
            str_reg[ch] <= 4'h0;                                                  // see RL17
         else if (rx_on & (clip > str_reg[ch]))
            str_reg[ch] <= clip;                                                  // see RL17
      end
   end

   // checks
   state_max_a: assert property (@(posedge clk_i) disable iff (rst_i)        // see RL21
      (state_reg <= rx_gain_pkg::STATE_MAX)) else $error("gain state beyond max");
   ladder_map_a: assert property (@(posedge clk_i) disable iff (rst_i)       // see RL8
      (state_reg > 4'h4) |-> (window_step_o == 3'h4 && stage23_red_o == 3'(state_reg - 4'h4)))
      else $error("ladder mapping wrong");
   reset_cmd_a: assert property (@(posedge clk_i) disable iff (rst_i)        // see RL6
      cmd_reset |=> (state_reg == $past(manual_reg))) else $error("reset gain not loaded");
   first_write_a: assert property (@(posedge clk_i) disable iff (rst_i)      // see RL2
      !wr_first |=> $stable(first_reg)) else $error("first gain changed without write");
   capture_fall_a: assert property (@(posedge clk_i) disable iff (rst_i)     // see RL13
      rx_fall |=> (captured_reg == $past(state_reg))) else $error("state not captured");
   sq_start_a: assert property (@(posedge clk_i) disable iff (rst_i)         // see RL10
      (tx_end_i && sq_en) |=> !sq_on_reg [*8]) else $error("squelch started too early");
   sq_step_a: assert property (@(posedge clk_i) disable iff (rst_i)          // see RL12
      (sq_per_end && sq_trans_reg <= 4'h2) |=> (state_reg == $past(state_reg) || $past(cmd_reset)
      || $past(rx_fall) || $past(rx_rise) || $past(agc_step)))
      else $error("squelch stepped on quiet period");
   str_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)        // see RL19
      (cmd_clear || agc_step) |=> (str_reg[0] == 4'h0 && str_reg[1] == 4'h0))
      else $error("strength not cleared");
   str_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)       // see RL17
      (!rx_on && !rx_on_q_reg && !cmd_clear && !cmd_reset) |=> $stable(str_reg[0]))
      else $error("strength moved while receiver off");
   str_max_a: assert property (@(posedge clk_i) disable iff (rst_i)          // see RL18
      str_reg[0] <= 4'hD && str_reg[1] <= 4'hD) else $error("strength above max code");
   power_a: assert property (@(posedge clk_i) disable iff (rst_i)            // see RL20
      !rx_power_o |=> !rx_on_q_reg) else $error("receiver on without power");
   cover_sq_step_c: cover property (@(posedge clk_i) disable iff (rst_i) sq_step);
   cover_agc_step_c: cover property (@(posedge clk_i) disable iff (rst_i) agc_step ##1 agc_step);
   cover_capture_c: cover property (@(posedge clk_i) disable iff (rst_i)
      rx_rise ##[1:200] rx_fall);
   cover_max_c: cover property (@(posedge clk_i) disable iff (rst_i) at_max);
endmodule
`default_nettype wire

// ===== verif/tag_response_model.sv
`timescale 1ns/1ps
`default_nettype none
module tag_response_model (
   // clock and burst control
   input  wire logic       clk_i,
   input  wire logic [3:0] mask_i,
   input  wire logic [3:0] level_i,
   // comparator lines toward the block
   output logic            dig_main_o,
   output logic            dig_win6_o,
   output logic            dig_agc3_o,
   output logic            dig_agc6_o,
   output logic            pulse_o,
   output logic [3:0]      strength_a_o,
   output logic [3:0]      strength_b_o
);
   // toggles only while a burst is on, so idle lines stay quiet
   logic t_reg = 1'b0;
   always_ff @(posedge clk_i) begin
      if (mask_i != 4'h0) t_reg <= ~t_reg;
   end
   assign {dig_main_o, dig_win6_o, dig_agc3_o, dig_agc6_o} = mask_i & {4{t_reg}};
   assign pulse_o = t_reg;
   // channel b sits one step below a to catch swapped nibbles
   assign strength_a_o = level_i;
   assign strength_b_o = level_i - 4'h1;
endmodule
`default_nettype wire

// ===== verif/rx_gain_agc_squelch_rssi_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rx_gain_agc_squelch_rssi_tb_top;
   localparam int SQP = 50;
   logic        clk_i, rst_i, cyc, stb, we, ack_o, rx_on, tx_end, sq_o, boost_o, pwr_o;
   logic        d_main, d_win6, d_agc3, d_agc6, pulse;
   logic [7:0]  adr, mtimer;
   logic [3:0]  sel, mask, level, str_a, str_b;
   logic [31:0] dat, dat_o, q;
   logic [2:0]  lp_o, fz_o, red1_o, win_o, red23_o;
   logic [1:0]  tz_o;
   int          fail_count, comparisons, cycles;
   logic [3:0]  zc [9] = '{4'h0, 4'h4, 4'h2, 4'h1, 4'h3, 4'h5, 4'h8, 4'hC, 4'hF};
   // {first zero, third zero} in enum order
   logic [4:0]  ze [9] = '{5'h00, 5'h01, 5'h06, 5'h05, 5'h0A, 5'h09, 5'h0C, 5'h0D, 5'h13};
   logic [2:0]  lpc [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7};

   rx_gain_agc_squelch_rssi #(.SQ_PERIOD(SQP)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .rx_on_i(rx_on),
      .tx_end_i(tx_end), .receive_mask_timer_i(mtimer), .dig_main_i(d_main),
      .dig_win6_i(d_win6), .dig_agc3_i(d_agc3), .dig_agc6_i(d_agc6),
      .subcarrier_pulse_i(pulse), .strength_a_i(str_a), .strength_b_i(str_b),
      .rx_power_o(pwr_o), .lowpass_o(lp_o), .first_zero_o(fz_o), .third_zero_o(tz_o),
      .first_red_o(red1_o), .first_boost_o(boost_o), .window_step_o(win_o),
      .stage23_red_o(red23_o), .squelch_active_o(sq_o));
   tag_response_model tag (
      .clk_i(clk_i), .mask_i(mask), .level_i(level), .dig_main_o(d_main),
      .dig_win6_o(d_win6), .dig_agc3_o(d_agc3), .dig_agc6_o(d_agc6), .pulse_o(pulse),
      .strength_a_o(str_a), .strength_b_o(str_b));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task results;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         results();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // bus holds until ack is sampled, then releases for one idle cycle
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_i);
      {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o;
      {cyc, stb, we} <= 3'b000;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0, 4'hF);
      chk(q, e);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      wb(1'b1, a, d, s);
      // the write lands at the ack edge; let it settle before outputs are compared
      @(posedge clk_i);
   endtask
   task lad(input logic [3:0] s);
      chk({win_o, red23_o},
          (s > rx_gain_pkg::WINDOW_STEPS) ? {3'h4, 3'(s - 4'h4)} : {s[2:0], 3'h0});
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   initial begin
      {cyc, stb, we, rx_on, tx_end, adr, mtimer, sel, mask, level, dat} = '0;
      rst_i = 1'b1;
      wt(20);
      rst_i <= 1'b0;
      wt(1);
      chk({pwr_o, boost_o, red1_o}, 32'h6);
      lad(0);
      rd(rx_gain_pkg::OFS_FIRST, 32'h6);
      rd(8'h20, 32'h0);
      wr(rx_gain_pkg::OFS_FIRST, 32'h9);
      wr(rx_gain_pkg::OFS_FIRST, 32'h0, 4'h0);
      rd(rx_gain_pkg::OFS_FIRST, 32'h9);
      chk({boost_o, red1_o}, 32'h9);
      for (int i = 0; i < 6; i++) begin
         wr(rx_gain_pkg::OFS_FILTER, {lpc[i], 4'h0});
         chk(lp_o, i);
      end
      for (int i = 0; i < 9; i++) begin
         wr(rx_gain_pkg::OFS_FILTER, zc[i]);
         chk({fz_o, tz_o}, ze[i]);
      end
      wr(rx_gain_pkg::OFS_MANUAL, 32'h3);
      wr(rx_gain_pkg::OFS_CMD, 32'h1);
      lad(3);
      wr(rx_gain_pkg::OFS_SQTIMER, 32'h80);
      wr(rx_gain_pkg::OFS_LOOP, 32'h41);
      chk(pwr_o, 1);
      tx_end <= 1'b1;
      wt(1);
      tx_end <= 1'b0;
      wt(rx_gain_pkg::SQ_DELAY_CYC - 4);
      chk(sq_o, 0);
      wt(8);
      chk(sq_o, 1);
      mask <= 4'h4;
      wt(SQP * 2 + 2);
      lad(3);
      mask <= 4'h8;
      wt(SQP * 8 + 10);
      lad(10);
      mask <= 4'h0;
      mtimer <= 8'h80;
      wt(3);
      chk(sq_o, 0);
      wr(rx_gain_pkg::OFS_CMD, 32'h1);
      wr(rx_gain_pkg::OFS_LOOP, 32'h4C);
      level <= 4'h5;
      rx_on <= 1'b1;
      mask <= 4'h1;
      wt(10);
      lad(3);
      rd(rx_gain_pkg::OFS_STRENGTH, 32'h45);
      level <= 4'h2;
      mask <= 4'h2;
      wt(20);
      mask <= 4'h0;
      wt(3);
      lad(10);
      rd(rx_gain_pkg::OFS_STRENGTH, 32'h12);
      level <= 4'h1;
      wr(rx_gain_pkg::OFS_CMD, 32'h2);
      wt(2);
      rd(rx_gain_pkg::OFS_STRENGTH, 32'h01);
      rx_on <= 1'b0;
      wt(2);
      level <= 4'hE;
      wt(2);
      rd(rx_gain_pkg::OFS_STRENGTH, 32'h01);
      rd(rx_gain_pkg::OFS_STATE, 32'hA);
      lad(3);
      wr(rx_gain_pkg::OFS_LOOP, 32'h5C);
      wr(rx_gain_pkg::OFS_MANUAL, 32'h0);
      wr(rx_gain_pkg::OFS_CMD, 32'h1);
      rx_on <= 1'b1;
      wt(3);
      lad(4);
      rx_on <= 1'b0;
      wr(rx_gain_pkg::OFS_LOOP, 32'h44);
      rx_on <= 1'b1;
      mask <= 4'h8;
      wt(20);
      mask <= 4'h2;
      wt(10);
      mask <= 4'h0;
      lad(0);
      rx_on <= 1'b0;
      wt(2);
      results();
   end
endmodule
`default_nettype wire
